// [verilog/bscan_adc_pkg.sv]
/*
 * Constants for the boundary-scan data register and the converter
 * engine: chain length, cell positions, reset image and timing.
 * Assumes a 20 MHz system clock; positions count from the serial
 * output end (position 0) toward the serial input end.
 */
package bscan_adc_pkg;

    localparam int CLK_PERIOD_NS = 50;
    localparam int CHAIN_LEN = 141;
    localparam int PIN_COUNT = 32;
    localparam int CODE_W = 10;
    localparam int CHAN_W = 8;

    // analog section, topmost part of the chain
    localparam int POS_ANALOG_MSB = 140;
    localparam int POS_ANALOG_LSB = 97;
    localparam int ANALOG_W = POS_ANALOG_MSB - POS_ANALOG_LSB + 1;
    localparam int POS_COMP_IDLE = 140;
    localparam int POS_COMP_OUT = 139;
    localparam int POS_COMP_MUX_EN = 138;
    localparam int POS_COMP_BANDGAP = 137;
    localparam int POS_CONV_COMPARE = 136;
    localparam int POS_RESERVED_ONE = 135;
    localparam int POS_RESERVED_TWO = 132;
    localparam int POS_CONV_ENABLE = 130;
    localparam int POS_TRIAL_MSB = 128;
    localparam int POS_TRIAL_LSB = 119;
    localparam int POS_BYPASS_GAIN = 118;
    localparam int POS_SAMPLE_HOLD = 114;
    localparam int POS_CHAN_MSB = 112;
    localparam int POS_CHAN_LSB = 105;
    localparam int POS_PASS_GATE = 101;
    localparam int POS_PRECHARGE = 100;

    // digital pin triples: value, direction, pull-up, value on top
    localparam int PORTB_TOP = 96;
    localparam int PORTD_TOP = 61;
    localparam int PORTC_LOW_TOP = 37;
    localparam int PORTC_HIGH_TOP = 31;
    localparam int PORTA_BASE = 2;
    localparam int CELL_STEP = 3;
    localparam int DIR_OFS = 1;
    localparam int PULL_OFS = 2;

    localparam logic [CODE_W-1:0] MIDPOINT_CODE = 10'h200;

    // recommended idle values; reserved cells stay zero
    localparam logic [CHAIN_LEN-1:0] CHAIN_RESET =
        (CHAIN_LEN'(1) << POS_BYPASS_GAIN) | (CHAIN_LEN'(1) << POS_SAMPLE_HOLD) |
        (CHAIN_LEN'(1) << POS_CHAN_LSB) | (CHAIN_LEN'(1) << POS_PASS_GATE) |
        (CHAIN_LEN'(1) << POS_PRECHARGE);

    // converter timing
    localparam int SAMPLE_NS = 100;
    localparam int SETTLE_NS = 150;
    localparam int TESTER_WAIT_NS = 200;
    localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TESTER_WAIT_CYC = (TESTER_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        CONV_IDLE = 2'b00,
        CONV_SAMPLE = 2'b01,
        CONV_TRIAL = 2'b10
    } conv_state_t;

    // value-cell position of pin port*8+bit, -1 when not chained
    function automatic int value_cell_pos(input int pin);
        int port;
        int b;
        port = pin / 8;
        b = pin % 8;
        value_cell_pos = -1;
        unique case (port)
            0: value_cell_pos = PORTA_BASE + CELL_STEP * b; // RULE_05
            1: value_cell_pos = PORTB_TOP - CELL_STEP * b;
            2: begin
                if (b < 2) begin
                    value_cell_pos = PORTC_LOW_TOP - CELL_STEP * b;
                end else if (b > 5) begin
                    value_cell_pos = PORTC_HIGH_TOP - CELL_STEP * (b - 6);
                end
            end
            default: value_cell_pos = PORTD_TOP - CELL_STEP * b;
        endcase
    endfunction

endpackage

// [verilog/level_sync.sv]
/*
 * Two-flop level synchroniser, WIDTH independent bits.
 * Assumes each bit is a slow level; no multi-bit coherence.
 */
`timescale 1ns/1ps

module level_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic [WIDTH-1:0] d_in,
    output logic [WIDTH-1:0] q_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] q_r;
    logic [WIDTH-1:0] q_nxt;

    always_comb begin
        meta_nxt = d_in;
        q_nxt = meta_r;
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            q_r <= q_nxt;
        end
    end

    assign q_out = q_r;

endmodule // level_sync

// [verilog/bscan_adc_chain.sv]
/*
 * Boundary-scan data register with the converter and comparator
 * cells, port pin cells, and the successive-approximation engine.
 * Assumes the TAP controller supplies capture/shift/update strobes
 * and the extest decode on the test clock; analog parts lie outside.
 */
`timescale 1ns/1ps

// Summary of operation
// RULE_01: position 0 shifts in first, out first
// RULE_02: trial code at 128..119, analog top 140
// RULE_03: analog cells hold the top chain positions
// RULE_04: pin cells follow package pin order
// RULE_05: first port chained in reverse bit order
// RULE_06: each pin: value, direction, pull-up triple
// RULE_07: third port pins 2..5 never chained
// RULE_08: digital successive-approximation search drives trial code
// RULE_09: enabling converter runs ten-comparison dummy conversion
// RULE_10: tester waits 200 ns after enabling
// RULE_11: tester holds midpoint code while sampling
// RULE_12: tester sets analog pin input, no pull-up
// RULE_13: lower limit expects low, upper expects high
// RULE_14: tester follows preload, extest limit sequence
// RULE_15: tester checks results on next shift
// RULE_16: test clock fast enough for hold span
// RULE_17: sample-hold cell low samples, high holds
// RULE_18: precharge cell active low
// RULE_19: tester loads zero into reserved cells
// RULE_20: comparator result captured each capture phase
module bscan_adc_chain (
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic tck_in,
    input wire logic tdi_in,
    input wire logic bscan_select_in,
    input wire logic capture_dr_in,
    input wire logic shift_dr_in,
    input wire logic update_dr_in,
    input wire logic extest_in,
    output logic tdo_out,
    input wire logic [bscan_adc_pkg::PIN_COUNT-1:0] pin_level_in,
    input wire logic [bscan_adc_pkg::PIN_COUNT-1:0] core_pin_value_in,
    input wire logic [bscan_adc_pkg::PIN_COUNT-1:0] core_pin_direction_in,
    input wire logic [bscan_adc_pkg::PIN_COUNT-1:0] core_pin_pullup_in,
    output logic [bscan_adc_pkg::PIN_COUNT-1:0] pin_value_out,
    output logic [bscan_adc_pkg::PIN_COUNT-1:0] pin_direction_out,
    output logic [bscan_adc_pkg::PIN_COUNT-1:0] pin_pullup_out,
    input wire logic converter_compare_in,
    input wire logic comparator_level_in,
    input wire logic converter_enable_in,
    input wire logic conversion_start_in,
    input wire logic [bscan_adc_pkg::CHAN_W-1:0] channel_select_in,
    output logic converter_enable_out,
    output logic [bscan_adc_pkg::CODE_W-1:0] trial_code_out,
    output logic sample_hold_out,
    output logic comparator_precharge_n_out,
    output logic [bscan_adc_pkg::CHAN_W-1:0] channel_select_lines_out,
    output logic [bscan_adc_pkg::ANALOG_W-1:0] analog_ctl_out,
    output logic [bscan_adc_pkg::CODE_W-1:0] result_out,
    output logic result_valid_out,
    output logic busy_out
);
    import bscan_adc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // crossings

    logic [PIN_COUNT-1:0] pin_level_tck;
    logic [1:0] cmp_pair_tck;
    logic cmp_sys;
    logic extest_sys;

    // pins and comparators are asynchronous to the test clock
    level_sync #(.WIDTH(PIN_COUNT)) u_pin_sync (
        .clk_in(tck_in),
        .arst_n_in(arst_n_in),
        .d_in(pin_level_in),
        .q_out(pin_level_tck)
    );

    level_sync #(.WIDTH(2)) u_cmp_tck_sync (
        .clk_in(tck_in),
        .arst_n_in(arst_n_in),
        .d_in({comparator_level_in, converter_compare_in}),
        .q_out(cmp_pair_tck)
    );

    // converter engine stands down while the chain owns the converter
    level_sync #(.WIDTH(2)) u_sys_sync (
        .clk_in(clk_sys_in),
        .arst_n_in(arst_n_in),
        .d_in({extest_in, converter_compare_in}),
        .q_out({extest_sys, cmp_sys})
    );

    ////////////////////////////////////////////////////////////////////
    // scan chain, test clock domain

    logic [CHAIN_LEN-1:0] shift_r;
    logic [CHAIN_LEN-1:0] shift_nxt;
    logic [CHAIN_LEN-1:0] update_r;
    logic [CHAIN_LEN-1:0] update_nxt;
    logic [CHAIN_LEN-1:0] capture_vec;

    always_comb begin
        int p;
        p = 0;
        // control cells read back their own update stage
        capture_vec = update_r;
        capture_vec[POS_CONV_COMPARE] = cmp_pair_tck[0]; // RULE_20
        capture_vec[POS_COMP_OUT] = cmp_pair_tck[1]; // RULE_20
        for (int i = 0; i < PIN_COUNT; i++) begin
            p = value_cell_pos(i); // RULE_04
            if (p >= 0) begin
                capture_vec[p] = pin_level_tck[i];
            end
        end
    end

    always_comb begin
        shift_nxt = shift_r;
        update_nxt = update_r;
        if (bscan_select_in && capture_dr_in) begin
            shift_nxt = capture_vec; // RULE_20
        end else if (bscan_select_in && shift_dr_in) begin
            // serial input enters at the top, bit 0 leaves first
            shift_nxt = {tdi_in, shift_r[CHAIN_LEN-1:1]}; // RULE_01
        end
        if (bscan_select_in && update_dr_in) begin
            update_nxt = shift_r;
        end
    end

    always_ff @(posedge tck_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            shift_r <= '0;
            update_r <= CHAIN_RESET; // RULE_19
        end else begin
            shift_r <= shift_nxt;
            update_r <= update_nxt;
        end
    end

    assign tdo_out = shift_r[0]; // RULE_01

    ////////////////////////////////////////////////////////////////////
    // pin drive: chained pins from the chain in extest, core otherwise

    for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
        localparam int VPOS = value_cell_pos(g);
        if (VPOS >= 0) begin : g_chained
            // value on top, then direction, then pull-up
            assign pin_value_out[g] = extest_in ? update_r[VPOS] : core_pin_value_in[g]; // RULE_06
            assign pin_direction_out[g] =
                extest_in ? update_r[VPOS-DIR_OFS] : core_pin_direction_in[g]; // RULE_06
            assign pin_pullup_out[g] =
                extest_in ? update_r[VPOS-PULL_OFS] : core_pin_pullup_in[g]; // RULE_06
        end else begin : g_tap_pin
            // these pins carry the TAP itself
            assign pin_value_out[g] = core_pin_value_in[g]; // RULE_07
            assign pin_direction_out[g] = core_pin_direction_in[g]; // RULE_07
            assign pin_pullup_out[g] = core_pin_pullup_in[g]; // RULE_07
        end
    end

    ////////////////////////////////////////////////////////////////////
    // converter engine, system clock domain

    conv_state_t state_r;
    conv_state_t state_nxt;
    logic [3:0] bit_r;
    logic [3:0] bit_nxt;
    logic [1:0] wait_r;
    logic [1:0] wait_nxt;
    logic [CODE_W-1:0] code_r;
    logic [CODE_W-1:0] code_nxt;
    logic [CODE_W-1:0] result_r;
    logic [CODE_W-1:0] result_nxt;
    logic valid_r;
    logic valid_nxt;
    logic dummy_r;
    logic dummy_nxt;
    logic en_prev_r;
    logic en_prev_nxt;
    logic hold_r;
    logic hold_nxt;

    always_comb begin
        logic [CODE_W-1:0] c;
        c = code_r;
        state_nxt = state_r;
        bit_nxt = bit_r;
        wait_nxt = wait_r;
        code_nxt = code_r;
        result_nxt = result_r;
        valid_nxt = 1'b0;
        dummy_nxt = dummy_r;
        en_prev_nxt = converter_enable_in;
        hold_nxt = hold_r;
        unique case (state_r)
            CONV_IDLE: begin
                hold_nxt = 1'b1;
                if (converter_enable_in && !extest_sys &&
                    (!en_prev_r || conversion_start_in)) begin
                    // a fresh enable runs a throwaway pass unless extest is active at that edge
                    dummy_nxt = !en_prev_r; // RULE_09
                    state_nxt = CONV_SAMPLE;
                    wait_nxt = 2'(SAMPLE_CYC - 1);
                    code_nxt = MIDPOINT_CODE;
                    hold_nxt = 1'b0;
                end
            end
            CONV_SAMPLE: begin
                if (wait_r == 2'h0) begin
                    state_nxt = CONV_TRIAL;
                    bit_nxt = 4'(CODE_W - 1);
                    wait_nxt = 2'(SETTLE_CYC - 1);
                    hold_nxt = 1'b1;
                end else begin
                    wait_nxt = wait_r - 2'h1;
                end
            end
            CONV_TRIAL: begin
                // settle covers analog delay plus the two sync flops
                if (wait_r == 2'h0) begin
                    if (cmp_sys) begin
                        c[bit_r] = 1'b0; // RULE_08
                    end
                    if (bit_r == 4'h0) begin
                        // ten comparisons done
                        state_nxt = CONV_IDLE; // RULE_09
                        code_nxt = c;
                        if (!dummy_r) begin
                            result_nxt = c;
                            valid_nxt = 1'b1;
                        end
                    end else begin
                        c[bit_r - 4'h1] = 1'b1; // RULE_08
                        code_nxt = c;
                        bit_nxt = bit_r - 4'h1;
                        wait_nxt = 2'(SETTLE_CYC - 1);
                    end
                end else begin
                    wait_nxt = wait_r - 2'h1;
                end
            end
            default: begin
                state_nxt = CONV_IDLE;
            end
        endcase
        // aborted conversions raise no result valid pulse
        if (extest_sys || !converter_enable_in) begin
            state_nxt = CONV_IDLE;
            hold_nxt = 1'b1;
            valid_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_r <= CONV_IDLE;
            bit_r <= 4'h0;
            wait_r <= 2'h0;
            code_r <= MIDPOINT_CODE;
            result_r <= '0;
            valid_r <= 1'b0;
            dummy_r <= 1'b0;
            en_prev_r <= 1'b0;
            hold_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            bit_r <= bit_nxt;
            wait_r <= wait_nxt;
            code_r <= code_nxt;
            result_r <= result_nxt;
            valid_r <= valid_nxt;
            dummy_r <= dummy_nxt;
            en_prev_r <= en_prev_nxt;
            hold_r <= hold_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // analog controls: chain in extest; engine, core inputs or idle constants otherwise
    // select is a test-clock level; glitches only at mode change

    assign converter_enable_out =
        extest_in ? update_r[POS_CONV_ENABLE] : converter_enable_in;
    assign trial_code_out =
        extest_in ? update_r[POS_TRIAL_MSB:POS_TRIAL_LSB] : code_r; // RULE_02
    // low samples, high holds
    assign sample_hold_out = extest_in ? update_r[POS_SAMPLE_HOLD] : hold_r; // RULE_17
    // zero precharges the comparator latch
    assign comparator_precharge_n_out = extest_in ? update_r[POS_PRECHARGE] : 1'b1; // RULE_18
    assign channel_select_lines_out =
        extest_in ? update_r[POS_CHAN_MSB:POS_CHAN_LSB] : channel_select_in;
    assign analog_ctl_out = extest_in ? update_r[POS_ANALOG_MSB:POS_ANALOG_LSB]
                                      : CHAIN_RESET[POS_ANALOG_MSB:POS_ANALOG_LSB]; // RULE_03

    assign result_out = result_r;
    assign result_valid_out = valid_r;
    assign busy_out = (state_r != CONV_IDLE);

endmodule // bscan_adc_chain

// [test/bscan_adc_chain_sva.sv]
/* Checker: scan timing, update cells, converter engine.
   Assumes whole 141-bit frames; bound at the foot. */
`timescale 1ns/1ps

module bscan_adc_chain_sva (
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic tck_in,
    input wire logic tdi_in,
    input wire logic bscan_select_in,
    input wire logic capture_dr_in,
    input wire logic shift_dr_in,
    input wire logic update_dr_in,
    input wire logic extest_in,
    input wire logic tdo_out,
    input wire logic [bscan_adc_pkg::PIN_COUNT-1:0] core_pin_value_in,
    input wire logic [bscan_adc_pkg::PIN_COUNT-1:0] core_pin_direction_in,
    input wire logic [bscan_adc_pkg::PIN_COUNT-1:0] core_pin_pullup_in,
    input wire logic [bscan_adc_pkg::PIN_COUNT-1:0] pin_value_out,
    input wire logic [bscan_adc_pkg::PIN_COUNT-1:0] pin_direction_out,
    input wire logic [bscan_adc_pkg::PIN_COUNT-1:0] pin_pullup_out,
    input wire logic converter_enable_in,
    input wire logic conversion_start_in,
    input wire logic [bscan_adc_pkg::CODE_W-1:0] trial_code_out,
    input wire logic sample_hold_out,
    input wire logic comparator_precharge_n_out,
    input wire logic result_valid_out,
    input wire logic busy_out
);
    import bscan_adc_pkg::*;
    ////////////////////////////////////////////////////////////////
    // saturating run lengths
    logic [7:0] shift_cnt_r, shift_cnt_nxt;
    logic [5:0] busy_cnt_r, busy_cnt_nxt;
    always_comb shift_cnt_nxt = (bscan_select_in && shift_dr_in && !capture_dr_in) ?
        ((shift_cnt_r == 8'hFF) ? shift_cnt_r : shift_cnt_r + 8'h01) : 8'h00;
    always_comb busy_cnt_nxt = busy_out ? ((busy_cnt_r == 6'h3F) ? busy_cnt_r :
        busy_cnt_r + 6'h01) : 6'h00;
    always_ff @(posedge tck_in or negedge arst_n_in) begin
        if (!arst_n_in) shift_cnt_r <= 8'h00;
        else shift_cnt_r <= shift_cnt_nxt;
    end
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) busy_cnt_r <= 6'h00;
        else busy_cnt_r <= busy_cnt_nxt;
    end
    ////////////////////////////////////////////////////////////////
    a_tdo_delay: assert property (@(posedge tck_in) disable iff (!arst_n_in)
        shift_cnt_r >= 8'h8D |-> tdo_out == $past(tdi_in, 141))
        else $error("tdo not tdi delayed by chain");
    a_update_analog: assert property (@(posedge tck_in) disable iff (!arst_n_in)
        (bscan_select_in && update_dr_in && extest_in && shift_cnt_r == 8'h8D) |=>
        trial_code_out[9] == $past(tdi_in, 14) && trial_code_out[0] == $past(tdi_in, 23) &&
        sample_hold_out == $past(tdi_in, 28) && comparator_precharge_n_out == $past(tdi_in, 42))
        else $error("analog cells misplaced");
    a_update_pins: assert property (@(posedge tck_in) disable iff (!arst_n_in)
        (bscan_select_in && update_dr_in && extest_in && shift_cnt_r == 8'h8D) |=>
        pin_value_out[3] == $past(tdi_in, 131) && pin_direction_out[8] == $past(tdi_in, 47) &&
        pin_pullup_out[31] == $past(tdi_in, 104) && pin_value_out[22] == $past(tdi_in, 111))
        else $error("pin cells misplaced");
    a_portc_core: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        pin_direction_out[21:18] == core_pin_direction_in[21:18])
        else $error("TAP pins not core driven");
    a_core_outside: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        !extest_in |-> pin_value_out == core_pin_value_in && pin_pullup_out == core_pin_pullup_in)
        else $error("pins not core driven");
    a_start_busy: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (conversion_start_in && converter_enable_in && !busy_out && !extest_in &&
        !$past(extest_in, 3)) |-> ##[1:3] busy_out)
        else $error("start request not taken");
    a_sample_hold: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        ($rose(busy_out) && !extest_in) |-> !sample_hold_out [*2] ##1 sample_hold_out)
        else $error("sample phase length");
    a_hold_mid: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        (!extest_in && busy_out && !sample_hold_out) |-> trial_code_out == 10'h200)
        else $error("code off midpoint");
    a_valid_pulse: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        result_valid_out |=> !result_valid_out)
        else $error("valid too long");
    a_valid_end: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        $rose(result_valid_out) |-> $past(busy_out, 30))
        else $error("result too early");
    a_busy_bound: assert property (@(posedge clk_sys_in) disable iff (!arst_n_in)
        busy_cnt_r <= 6'h21)
        else $error("conversion runs too long");
endmodule // bscan_adc_chain_sva

bind bscan_adc_chain bscan_adc_chain_sva chk_u (.*);

// [test/scan_tester.sv]
/* Test controller model: full scans, 80 ns test clock.
   Assumes the bench picks the mode; clock idles between frames. */
`timescale 1ns/1ps

module scan_tester (
    output logic tck_out,
    output logic tdi_out,
    output logic select_out,
    output logic capture_out,
    output logic shift_out,
    output logic update_out,
    output logic extest_out,
    input wire logic tdo_in
);
    initial {tck_out, tdi_out, select_out, capture_out, shift_out, update_out, extest_out} = 7'h00;
    ////////////////////////////////////////////////////////////////
    // values change 1 ns after each rise
    task automatic step(input logic c, input logic s, input logic u, input logic d);
        #39 tck_out = 1'b1;
        #1;
        capture_out = c;
        shift_out = s;
        update_out = u;
        tdi_out = d;
        #40 tck_out = 1'b0;
    endtask
    // idle edges first: capture synchronisers need two test clocks
    task automatic run(input logic ext, input logic [140:0] img, output logic [140:0] got);
        extest_out = ext;
        select_out = 1'b1;
        repeat (3) step(1'b0, 1'b0, 1'b0, ~tdi_out);
        step(1'b1, 1'b0, 1'b0, ~tdi_out);
        step(1'b0, 1'b1, 1'b0, img[0]);
        for (int k = 0; k < 141; k++) begin
            got[k] = tdo_in;
            step(1'b0, k < 140, k == 140, (k < 140) ? img[k + 1] : ~tdi_out);
        end
        repeat (2) step(1'b0, 1'b0, 1'b0, ~tdi_out);
        select_out = 1'b0;
    endtask
endmodule // scan_tester

// [test/tb_bscan_adc_chain.sv]
/* Testbench: conversions, mid-run reset, limit-check scans.
   Assumes scan_tester drives the test port; comparator modelled here. */
`timescale 1ns/1ps

module tb_bscan_adc_chain;
    import bscan_adc_pkg::*;
    typedef struct packed {logic [9:0] vin; logic [9:0] res;} row_t;
    // pin patterns keep bit 3 (analog channel pin) an input, no pull-up
    localparam logic [31:0] PV = 32'hA5C396E1;
    localparam logic [31:0] PD = 32'h5A3C6972;
    localparam logic [31:0] PU = 32'h0FF033C4;
    localparam logic [31:0] PL = 32'h3C5AF00F;
    localparam logic [31:0] CM = 32'h003C0000;
    row_t rows [5] = '{'{10'h000, 10'h000}, '{10'h3FF, 10'h3FF}, '{10'h123, 10'h123},
        '{10'h200, 10'h200}, '{10'h155, 10'h155}};
    logic clk_sys_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic tck_in, tdi_in, bscan_select_in, capture_dr_in, shift_dr_in, update_dr_in;
    logic extest_in, tdo_out, converter_enable_out, sample_hold_out;
    logic comparator_precharge_n_out, result_valid_out, busy_out;
    logic [31:0] pin_level_in = PL;
    logic [31:0] core_pin_value_in = ~PV;
    logic [31:0] core_pin_direction_in = ~PD;
    logic [31:0] core_pin_pullup_in = ~PU;
    logic [31:0] pin_value_out, pin_direction_out, pin_pullup_out;
    logic comparator_level_in = 1'b0;
    logic converter_enable_in = 1'b0;
    logic conversion_start_in = 1'b0;
    logic [7:0] channel_select_in = 8'h01;
    logic [7:0] channel_select_lines_out;
    logic [9:0] trial_code_out, result_out;
    logic [9:0] vin = 10'h000;
    logic [43:0] analog_ctl_out;
    // comparator: high while the code exceeds the input
    wire converter_compare_in = (vin < trial_code_out);
    logic [140:0] got;
    int mismatches = 0;
    int n_compared = 0;
    int n_valid = 0;
    ////////////////////////////////////////////////////////////////
    bscan_adc_chain dut_u (.*);
    scan_tester tester_u (.tck_out(tck_in), .tdi_out(tdi_in), .select_out(bscan_select_in),
        .capture_out(capture_dr_in), .shift_out(shift_dr_in), .update_out(update_dr_in),
        .extest_out(extest_in), .tdo_in(tdo_out));
    initial forever #25 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) if (result_valid_out === 1'b1) n_valid++;
    initial begin
        #400000;
        mismatches++;
        finish_test();
    end
    ////////////////////////////////////////////////////////////////
    function automatic int pos_of(input int p);
        int b;
        b = p % 8;
        case (p / 8)
            0: pos_of = 2 + 3 * b;
            1: pos_of = 96 - 3 * b;
            2: pos_of = (b < 2) ? 37 - 3 * b : (b > 5) ? 49 - 3 * b : -1;
            default: pos_of = 61 - 3 * b;
        endcase
    endfunction
    function automatic logic [140:0] mk(input logic [9:0] code, input logic hold, input logic pre);
        mk = '0;
        mk[130] = 1'b1;
        mk[128:119] = code;
        mk[118] = 1'b1;
        mk[114] = hold;
        mk[112:105] = 8'h08;
        mk[101] = 1'b1;
        mk[100] = pre;
        for (int p = 0; p < 32; p++) begin
            if (pos_of(p) >= 0) begin
                mk[pos_of(p)] = PV[p];
                mk[pos_of(p) - 1] = PD[p];
                mk[pos_of(p) - 2] = PU[p];
            end
        end
    endfunction
    function automatic logic [31:0] cap_word();
        for (int p = 0; p < 32; p++) cap_word[p] = (pos_of(p) < 0) ? PL[p] : got[pos_of(p)];
    endfunction
    task automatic chk(input string name, input logic [43:0] exp, input logic [43:0] seen);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic finish_test();
        if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [9:0] lim [2];
        logic [140:0] img;
        int n;
        lim = '{10'h123, 10'h143};
        repeat (2) @(posedge clk_sys_in);
        arst_n_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        converter_enable_in <= 1'b1;
        wait_cyc(TESTER_WAIT_CYC);
        chk("dummy busy", 1'b1, busy_out);
        n = 0;
        while (busy_out !== 1'b0 && n < 80) begin wait_cyc(1); n++; end
        chk("dummy valid", 44'(n_valid), 44'h0);
        foreach (rows[i]) begin
            @(posedge clk_sys_in);
            vin <= rows[i].vin;
            conversion_start_in <= 1'b1;
            @(posedge clk_sys_in);
            conversion_start_in <= 1'b0;
            n = 0;
            while (result_valid_out !== 1'b1 && n < 60) begin wait_cyc(1); n++; end
            chk("result", rows[i].res, result_out);
        end
        @(posedge clk_sys_in);
        arst_n_in <= 1'b0;
        wait_cyc(1);
        chk("reset result", 10'h000, result_out);
        chk("reset hold", 1'b1, sample_hold_out);
        chk("reset precharge", 1'b1, comparator_precharge_n_out);
        chk("reset code", MIDPOINT_CODE, trial_code_out);
        chk("reset busy", 1'b0, busy_out);
        @(posedge clk_sys_in);
        arst_n_in <= 1'b1;
        wait_cyc(40);
        @(posedge clk_sys_in);
        vin <= 10'h130;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_sys_in);
            comparator_level_in <= i[0];
            tester_u.run(1'b1, mk(MIDPOINT_CODE, 1'b0, 1'b1), got);
            chk("sampling", 1'b0, sample_hold_out);
            img = mk(lim[i], 1'b1, 1'b0);
            tester_u.run(1'b1, img, got);
            chk("limit code", lim[i], trial_code_out);
            chk("precharge", 1'b0, comparator_precharge_n_out);
            chk("channel", 8'h08, channel_select_lines_out);
            chk("analog", img[140:97], analog_ctl_out);
            chk("pin value", (PV & ~CM) | (~PV & CM), pin_value_out);
            chk("pin dir", (PD & ~CM) | (~PD & CM), pin_direction_out);
            chk("pin pull", (PU & ~CM) | (~PU & CM), pin_pullup_out);
            tester_u.run(1'b1, mk(MIDPOINT_CODE, 1'b1, 1'b1), got);
            chk("compare bit", lim[i] > 10'h130, got[136]);
            chk("code back", lim[i], got[128:119]);
            chk("comp level", i[0], got[139]);
            chk("pin capture", PL, cap_word());
        end
        finish_test();
    end
endmodule // tb_bscan_adc_chain
